// ===== rtl/crsc_map.svh
// constants for the cpu reset and slowdown control block
// assumes a 10 MHz core clock and an axi4-lite register port
//
// Summary of operation
// R01 - An 8-bit read/write control register clears to zero at reset and its bits 7:4 are reserved.
// R02 - A reset starts only when the trigger bit 2 rises from 0 to 1, with the select bits picking soft, hard or hard with self test.
// R03 - Software writes the select bits with the trigger at 0 first, then writes the same select bits with the trigger at 1.
// R04 - A hard reset holds the processor reset request for 2 ms and the pci bus reset for 1 ms.
// R05 - A soft reset asserts warm-start and never the hard reset request.
// R06 - Self test happens only within a hard reset, where bit 3 adds warm-start to the reset request.
// R07 - The companion chip drives processor reset after the request, and a processor seeing warm-start at its release enters self test.
// R08 - While slowdown bit 0 is 1 the cache-flush output is asserted and the pipeline is stalled at the slowdown counter rate.
// R09 - While slowdown bit 0 is 0 nothing is stalled and the slowdown counter has no effect.
// R10 - Systems with the companion i/o bridge should start hard resets through its port at 0x0CF9 instead of this register.
// R11 - Pulse widths are timed by counting core clock cycles derived from a clock frequency figure.
// R12 - Self test set with hard reset clear counts as a soft reset when the trigger rises.
`ifndef CRSC_MAP_SVH
`define CRSC_MAP_SVH

// ============================================================
// register indices (byte address is four times the index)
`define CRSC_IDX_CTRL    8'h93
`define CRSC_IDX_SLOW    8'h94
`define CRSC_IDX_STAT    8'h95
`define CRSC_CTRL_RESET  8'h00
`define CRSC_SLOW_RESET  8'h00

// ============================================================
// control field positions
`define CRSC_BIT_SLOW    0
`define CRSC_BIT_HARD    1
`define CRSC_BIT_TRIG    2
`define CRSC_BIT_BIST    3

// ============================================================
// timing
`define CRSC_CLK_MHZ     10
`define CRSC_CLK_KHZ     10000
`define CRSC_HARD_MS     2
`define CRSC_PCI_MS      1
`define CRSC_WARM_NS     2000
`define CRSC_BHOLD_US    100
`define CRSC_WARM_CYC    ((`CRSC_WARM_NS * `CRSC_CLK_MHZ + 999) / 1000)
`define CRSC_BHOLD_CYC   (`CRSC_BHOLD_US * `CRSC_CLK_MHZ)

`endif

// ===== rtl/crsc_pkg.sv
// types for the cpu reset and slowdown control block
// assumes nothing beyond the constants header
package crsc_pkg;

  // ============================================================
  // sequencer states
  typedef enum logic [1:0] {
    CRSC_IDLE  = 2'b00,
    CRSC_HARD  = 2'b01,
    CRSC_BHOLD = 2'b10,
    CRSC_SOFT  = 2'b11
  } crsc_state_t;

  // register selection
  typedef enum logic [1:0] {
    CRSC_SEL_NONE = 2'b00,
    CRSC_SEL_CTRL = 2'b01,
    CRSC_SEL_SLOW = 2'b10,
    CRSC_SEL_STAT = 2'b11
  } crsc_sel_t;

  // ============================================================
  // state of the top module
  typedef struct packed {
    crsc_state_t st;
    logic        aw_got;
    logic [11:0] awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  ctrl;
    logic [7:0]  slow_cnt;
    logic [8:0]  div;
    logic        stall;
    logic        req;
    logic        pci;
    logic        warm;
    logic        flush;
  } crsc_top_state_t;

  // state of the pulse timer
  typedef struct packed {
    logic [15:0] remain;
  } crsc_tmr_state_t;

endpackage : crsc_pkg

// ===== rtl/crsc_tmr_if.sv
// link between the sequencer and its pulse timer
// assumes both ends run on core_clk
interface crsc_tmr_if;
  logic        start;
  logic [15:0] load;
  logic [15:0] remain;

  modport ctrl (output start, output load, input remain);
  modport tmr  (input start, input load, output remain);
endinterface : crsc_tmr_if

// ===== rtl/crsc_pulse_timer.sv
// down-counting pulse timer for the reset sequencer
// assumes start is a one-cycle pulse and load is at least 2
module crsc_pulse_timer
  import crsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  crsc_tmr_if.tmr  tif
);

  crsc_tmr_state_t s_q;
  crsc_tmr_state_t s_d;

  // load on start, otherwise count down to zero and rest there
  always_comb begin
    s_d = s_q;
    if (tif.start) begin
      s_d.remain = tif.load; // see R11
    end else if (s_q.remain != 16'h0000) begin
      s_d.remain = s_q.remain - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.remain = s_q.remain;

endmodule : crsc_pulse_timer

// ===== rtl/crsc_top.sv
// cpu reset and slowdown control: axi4-lite register slave,
// reset sequencer and slowdown stall generator
// assumes synchronous inputs and a 10 MHz core_clk
//
// Chosen here: the AXI4-Lite register port.
`include "crsc_map.svh"

module crsc_top
  import crsc_pkg::*;
#(
  parameter int CLK_KHZ   = `CRSC_CLK_KHZ,
  parameter int HARD_CYC  = `CRSC_HARD_MS * CLK_KHZ,
  parameter int PCI_CYC   = `CRSC_PCI_MS * CLK_KHZ,
  parameter int BHOLD_CYC = `CRSC_BHOLD_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // processor and pci side
  output wire logic        processor_reset_request_n,
  output wire logic        pci_bus_reset_n,
  output wire logic        processor_warm_start_n,
  output wire logic        processor_cache_flush_n,
  output wire logic        processor_stall
);

  localparam logic [15:0] HARD_LD  = 16'(HARD_CYC);
  localparam logic [15:0] PCI_END  = 16'(HARD_CYC - PCI_CYC + 1);
  localparam logic [15:0] BHOLD_LD = 16'(BHOLD_CYC);
  localparam logic [15:0] WARM_LD  = 16'(`CRSC_WARM_CYC);
  localparam logic [1:0]  RESP_OK  = 2'b00;
  localparam logic [1:0]  RESP_ERR = 2'b10;

  // ============================================================
  // address decode, shared by the read and write paths
  function automatic crsc_sel_t crsc_decode(input logic [11:0] addr);
    crsc_sel_t sel;
    sel = CRSC_SEL_NONE;
    if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
      case (addr[9:2])
        `CRSC_IDX_CTRL: sel = CRSC_SEL_CTRL;
        `CRSC_IDX_SLOW: sel = CRSC_SEL_SLOW;
        `CRSC_IDX_STAT: sel = CRSC_SEL_STAT;
        default:        sel = CRSC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : crsc_decode

  crsc_top_state_t s_q;
  crsc_top_state_t s_d;
  crsc_tmr_if      tif ();

  crsc_pulse_timer u_timer (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tif      (tif)
  );

  // ============================================================
  // handshake readies
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;

  // ============================================================
  // next state
  always_comb begin
    logic [11:0] waddr;
    logic [31:0] wdat;
    logic [3:0]  wstb;
    logic        do_wr;
    logic        trig_rise;
    crsc_sel_t   wsel;
    crsc_sel_t   rsel;
    logic [7:0]  stat;
    waddr     = s_q.awaddr;
    wdat      = s_q.wdata;
    wstb      = s_q.wstrb;
    do_wr     = 1'b0;
    trig_rise = 1'b0;
    wsel      = CRSC_SEL_NONE;
    rsel      = CRSC_SEL_NONE;
    stat      = 8'h00;
    s_d       = s_q;
    tif.start = 1'b0;
    tif.load  = 16'h0000;

    // write channels: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
      waddr      = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      wdat      = s_axi_wdata;
      wstb      = s_axi_wstrb;
    end
    do_wr = s_d.aw_got && s_d.w_got && !s_q.bvalid;
    if (do_wr) begin
      wsel = crsc_decode(waddr);
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = (wsel == CRSC_SEL_NONE) ? RESP_ERR : RESP_OK;
      // registers live in byte lane 0 only
      if (wstb[0]) begin
        case (wsel)
          CRSC_SEL_CTRL: begin
            // reserved upper nibble always held at zero
            s_d.ctrl  = {4'h0, wdat[3:0]}; // see R01
            trig_rise = wdat[`CRSC_BIT_TRIG]
                        && !s_q.ctrl[`CRSC_BIT_TRIG]; // see R02
          end
          CRSC_SEL_SLOW: s_d.slow_cnt = wdat[7:0];
          default: ;
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // read channel; status shows the sequencer and slowdown state
    stat = {3'h0, s_q.flush, s_q.warm, s_q.pci, s_q.req,
            (s_q.st != CRSC_IDLE)};
    if (s_axi_arvalid && s_axi_arready) begin
      rsel       = crsc_decode(s_axi_araddr);
      s_d.rvalid = 1'b1;
      s_d.rresp  = (rsel == CRSC_SEL_NONE) ? RESP_ERR : RESP_OK;
      case (rsel)
        CRSC_SEL_CTRL: s_d.rdata = {24'h0, s_q.ctrl};
        CRSC_SEL_SLOW: s_d.rdata = {24'h0, s_q.slow_cnt};
        CRSC_SEL_STAT: s_d.rdata = {24'h0, stat};
        default:       s_d.rdata = 32'h0;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // reset sequencer; a trigger while busy is ignored
    case (s_q.st)
      CRSC_IDLE: begin
        if (trig_rise) begin
          // self test without hard reset falls back to soft
          if (s_d.ctrl[`CRSC_BIT_HARD]) begin // see R12
            tif.start = 1'b1;
            tif.load  = HARD_LD; // see R11
            s_d.req   = 1'b1; // see R04
            s_d.pci   = 1'b1; // see R04
            s_d.warm  = s_d.ctrl[`CRSC_BIT_BIST]; // see R06
            s_d.st    = CRSC_HARD;
          end else begin
            tif.start = 1'b1;
            tif.load  = WARM_LD;
            s_d.warm  = 1'b1; // see R05
            s_d.st    = CRSC_SOFT;
          end
        end
      end
      CRSC_HARD: begin
        // pci reset ends halfway, the request at the timer's end
        s_d.pci = s_q.pci && (tif.remain > PCI_END); // see R04
        if (tif.remain <= 16'h0001) begin
          s_d.req = 1'b0; // see R04
          if (s_q.warm) begin
            // warm-start must outlast the companion's reset release
            tif.start = 1'b1;
            tif.load  = BHOLD_LD; // see R07
            s_d.st    = CRSC_BHOLD;
          end else begin
            s_d.st = CRSC_IDLE;
          end
        end
      end
      CRSC_BHOLD, CRSC_SOFT: begin
        if (tif.remain <= 16'h0001) begin
          s_d.warm = 1'b0;
          s_d.st   = CRSC_IDLE;
        end
      end
      default: s_d.st = CRSC_IDLE;
    endcase

    // slowdown: one stall cycle every slow_cnt + 2 cycles
    if (s_q.ctrl[`CRSC_BIT_SLOW]) begin
      s_d.flush = 1'b1; // see R08
      s_d.stall = (s_q.div == {1'b0, s_q.slow_cnt} + 9'h001); // see R08
      s_d.div   = s_d.stall ? 9'h000 : s_q.div + 9'h001;
    end else begin
      s_d.flush = 1'b0; // see R09
      s_d.stall = 1'b0; // see R09
      s_d.div   = 9'h000;
    end
  end

  // ============================================================
  // single state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0; // see R01
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs, all from flip-flops
  assign s_axi_bvalid              = s_q.bvalid;
  assign s_axi_bresp               = s_q.bresp;
  assign s_axi_rvalid              = s_q.rvalid;
  assign s_axi_rresp               = s_q.rresp;
  assign s_axi_rdata               = s_q.rdata;
  assign processor_reset_request_n = !s_q.req;
  assign pci_bus_reset_n           = !s_q.pci;
  assign processor_warm_start_n    = !s_q.warm;
  assign processor_cache_flush_n   = !s_q.flush;
  assign processor_stall           = s_q.stall;

endmodule : crsc_top

// ===== test/crsc_top_checker.sv
// port assertions for crsc_top
// assumes a bind into crsc_top with its pulse counts handed on
`include "crsc_map.svh"
module crsc_top_checker #(
  parameter int HARD_CYC  = 20000,
  parameter int PCI_CYC   = 10000,
  parameter int BHOLD_CYC = 1000
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        processor_reset_request_n,
  input wire logic        pci_bus_reset_n,
  input wire logic        processor_warm_start_n,
  input wire logic        processor_cache_flush_n,
  input wire logic        processor_stall
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LONG = HARD_CYC + BHOLD_CYC;
  wire logic rq = processor_reset_request_n;
  wire logic pc = pci_bus_reset_n;
  wire logic wm = processor_warm_start_n;
  wire logic st = processor_stall;
  int        rq_q, pc_q, wm_q;
  // ==========================================================
  // low-time counters, read on the release edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rq_q <= 0;
      pc_q <= 0;
      wm_q <= 0;
    end else begin
      rq_q <= rq ? 0 : rq_q + 1;
      pc_q <= pc ? 0 : pc_q + 1;
      wm_q <= wm ? 0 : wm_q + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // properties
  a_req_width: assert property ($rose(rq) |-> rq_q == HARD_CYC)
    else $error("request width");
  a_pci_width: assert property ($rose(pc) |-> pc_q == PCI_CYC)
    else $error("pci reset width");
  a_pci_with_req: assert property ($fell(pc) |-> $fell(rq))
    else $error("pci reset alone");
  a_warm_len: assert property ($rose(wm) |-> wm_q inside {`CRSC_WARM_CYC, LONG})
    else $error("warm-start width");
  a_soft_no_req: assert property ($fell(wm) && rq |-> rq [*8])
    else $error("request in soft reset");
  a_bist_hold: assert property ($rose(rq) && !wm |-> !wm [*8])
    else $error("warm-start released early");
  a_stall_flush: assert property (st |-> !processor_cache_flush_n)
    else $error("stall outside slowdown");
  a_stall_pulse: assert property (st |=> !st)
    else $error("stall too long");
  a_rsv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("upper read bits set");
  c_hard: cover property ($fell(pc));
  c_soft: cover property ($fell(wm) && rq);
  c_stall: cover property (st);
endmodule : crsc_top_checker

bind crsc_top crsc_top_checker #(
  .HARD_CYC(HARD_CYC), .PCI_CYC(PCI_CYC), .BHOLD_CYC(BHOLD_CYC)
) u_chk (
  .core_clk, .arst_n, .s_axi_rdata, .s_axi_rvalid,
  .processor_reset_request_n, .pci_bus_reset_n, .processor_warm_start_n,
  .processor_cache_flush_n, .processor_stall
);

// ===== test/crsc_cpu_model.sv
// processors and companion chip on the far side of crsc_top
// assumes active-low request and warm-start on core_clk
module crsc_cpu_model (
  input  wire logic core_clk,
  input  wire logic processor_reset_request_n,
  input  wire logic processor_warm_start_n,
  output logic      processor_reset_n,
  output int        bist_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial processor_reset_n = 1'b1;
  initial bist_cnt = 0;
  // reset follows the request a cycle late; warm-start at release
  always @(posedge core_clk) begin
    if (!processor_reset_n && processor_reset_request_n &&
        !processor_warm_start_n) bist_cnt <= bist_cnt + 1;
    processor_reset_n <= processor_reset_request_n;
  end
endmodule : crsc_cpu_model

// ===== test/crsc_top_test.sv
// self-checking bench for crsc_top
// assumes shortened pulse counts and the cpu model beside it
`include "crsc_map.svh"
module crsc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 40;
  localparam int P = 20;
  localparam int B = 10;
  localparam logic [11:0] CTRL = {2'b00, `CRSC_IDX_CTRL, 2'b00};
  localparam logic [11:0] SLOW = {2'b00, `CRSC_IDX_SLOW, 2'b00};
  localparam logic [11:0] STAT = {2'b00, `CRSC_IDX_STAT, 2'b00};
  logic core_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, processor_stall, cpu_rst_n;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic processor_reset_request_n, pci_bus_reset_n;
  wire logic processor_warm_start_n, processor_cache_flush_n;
  int bist_cnt, n_errors, checks_done, rc, pc, wc, req_w, pci_w, warm_w;
  int n_stall;

  crsc_top #(.HARD_CYC(H), .PCI_CYC(P), .BHOLD_CYC(B)) DUT (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'b1), .processor_reset_request_n,
    .pci_bus_reset_n, .processor_warm_start_n, .processor_cache_flush_n,
    .processor_stall);
  crsc_cpu_model u_cpu (.core_clk, .processor_reset_request_n,
    .processor_warm_start_n, .processor_reset_n(cpu_rst_n), .bist_cnt);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // low widths and stall tally, read after the pulses end
  always @(posedge core_clk) begin
    rc = processor_reset_request_n ? 0 : rc + 1;
    req_w = processor_reset_request_n ? req_w : rc;
    pc = pci_bus_reset_n ? 0 : pc + 1;
    pci_w = pci_bus_reset_n ? pci_w : pc;
    wc = processor_warm_start_n ? 0 : wc + 1;
    warm_w = processor_warm_start_n ? warm_w : wc;
    n_stall += (processor_stall === 1'b1);
  end
  // ==========================================================
  // bus tasks and compare; bready and rready stay high
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // waits as long as it takes; only the watchdog ends a hang
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), {30'h0, a > 12'h254, 1'b0});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), {30'h0, a > 12'h254, 1'b0});
  endtask : rd
  // two-write trigger, then wait out the pulses
  task automatic fire(input logic [7:0] sel, input int cyc);
    req_w = 0;
    pci_w = 0;
    warm_w = 0;
    wr(CTRL, {24'h0, sel});
    wr(CTRL, {24'h0, sel | 8'h04});
    repeat (cyc) @(posedge core_clk);
  endtask : fire
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(CTRL, 0);
    rd(SLOW, 0);
    wr(CTRL, 32'hF0);
    rd(CTRL, 0);
    // lane 0 strobe low: nothing may be stored
    s_axi_wstrb <= 4'hE;
    wr(CTRL, 32'h01);
    s_axi_wstrb <= 4'hF;
    rd(CTRL, 0);
    wr(12'h300, 32'h1);
    rd(12'h300, 0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_hard();
    int b0 = bist_cnt;
    // no companion i/o bridge here, so this register may start it
    fire(8'h02, H + 5);
    chk(req_w, H);
    chk(pci_w, P);
    chk(warm_w + bist_cnt - b0, 0);
    chk(32'(cpu_rst_n), 1);
    // trigger already at one: rewriting it must not start a pulse
    req_w = 0;
    wr(CTRL, 32'h06);
    repeat (H) @(posedge core_clk);
    chk(req_w, 0);
    $display("t_hard done");
  endtask : t_hard
  task automatic t_bist();
    int b0 = bist_cnt;
    fire(8'h0A, H + B + 5);
    chk(req_w, H);
    chk(warm_w, H + B);
    chk(bist_cnt - b0, 1);
    $display("t_bist done");
  endtask : t_bist
  task automatic t_soft();
    for (int i = 0; i < 2; i++) begin
      fire(i ? 8'h08 : 8'h00, 30);
      chk(warm_w, `CRSC_WARM_CYC);
      chk(req_w + pci_w, 0);
    end
    $display("t_soft done");
  endtask : t_soft
  task automatic t_slow();
    for (int c = 0; c < 4; c += 3) begin
      wr(SLOW, 32'(c));
      wr(CTRL, 32'h01);
      @(negedge core_clk) n_stall = 0;
      repeat (50) @(negedge core_clk);
      chk(n_stall, 50 / (c + 2));
      chk(32'(processor_cache_flush_n), 0);
      rd(STAT, 32'h10);
      wr(CTRL, 32'h00);
      @(negedge core_clk) n_stall = 0;
      repeat (50) @(negedge core_clk);
      chk(n_stall + 32'(!processor_cache_flush_n), 0);
      @(posedge core_clk);
    end
    rd(SLOW, 3);
    $display("t_slow done");
  endtask : t_slow
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_hard();
    t_bist();
    t_soft();
    t_slow();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
endmodule : crsc_top_test
